/* File: rtl/mesf_defs.svh */
// constants for the meter event status flags block
`ifndef MESF_DEFS_SVH
`define MESF_DEFS_SVH

// register indices; byte address is four times the index
`define MESF_IDX_FLAGS       10'h310
`define MESF_IDX_SHADOW      10'h311
`define MESF_IDX_INT_STAT    10'h312
`define MESF_IDX_INT_CLR     10'h313
`define MESF_IDX_INT_EN      10'h314

// flag field positions
`define MESF_BIT_PULSE_ONE   0
`define MESF_BIT_PULSE_TWO   1
`define MESF_BIT_PULSE_THREE 2
`define MESF_BIT_PULSE_FOUR  3
`define MESF_BIT_FRESH_DATA  4
`define MESF_BIT_ENGINE_DONE 5
`define MESF_BIT_SUPPLY_CHG  7
`define MESF_BIT_RESET       8
`define MESF_MIRROR_LSB      16
`define MESF_MIRROR_RESET    24

// masks and reset values
`define MESF_FLAG_MASK       9'h1bf
`define MESF_FLAGS_RST       9'h100
`define MESF_SHADOW_RST      9'h000
`define MESF_INT_EN_RST      9'h000
`define MESF_INT_STAT_RST    9'h000

`endif

/* File: rtl/mesf_pkg.sv */
// types for the meter event status flags block
package mesf_pkg;
  typedef logic [8:0]  mesf_flags_t;
  typedef logic [31:0] mesf_word_t;
  typedef enum logic {BUS_IDLE, BUS_ACK} mesf_bus_st_t;
endpackage

/* File: rtl/mesf_evt_if.sv */
// event vector carried from the edge detector to the flag register
`timescale 1ns/1ps
`default_nettype none
interface mesf_evt_if;
  import mesf_pkg::*;
  mesf_flags_t evt;
  logic        armed;
  modport src (output evt, output armed);
  modport dst (input evt, input armed);
endinterface
`default_nettype wire

/* File: rtl/mesf_event_detect.sv */
// edge detector turning raw event inputs into one-cycle event pulses
`timescale 1ns/1ps
`default_nettype none
`include "mesf_defs.svh"
module mesf_event_detect
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic energyPulseOne,
  input  wire logic energyPulseTwo,
  input  wire logic energyPulseThree,
  input  wire logic energyPulseFour,
  input  wire logic freshDataStrobe,
  input  wire logic enginePassDone,
  input  wire logic systemSupplyIndicator,
  mesf_evt_if.src   evtIf
);
  import mesf_pkg::*;

  logic [6:0] prev_r;
  logic       armed_r;
  logic [6:0] now;

  assign now = {systemSupplyIndicator, enginePassDone, freshDataStrobe,
                energyPulseFour, energyPulseThree, energyPulseTwo, energyPulseOne};

  ////////////////////////////////////////////////////////////////////////////
  // previous levels; first clock after reset only primes them
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prev_r  <= 7'h00;
      armed_r <= 1'b0;
    end
    else
    begin
      prev_r  <= now;
      armed_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rising edges for pulse starts and strobes, any edge for supply
  always_comb
  begin
    evtIf.evt = 9'h000;
    if (armed_r)
    begin
      evtIf.evt[`MESF_BIT_PULSE_ONE]   = now[0] & ~prev_r[0];
      evtIf.evt[`MESF_BIT_PULSE_TWO]   = now[1] & ~prev_r[1];
      evtIf.evt[`MESF_BIT_PULSE_THREE] = now[2] & ~prev_r[2];
      evtIf.evt[`MESF_BIT_PULSE_FOUR]  = now[3] & ~prev_r[3];
      evtIf.evt[`MESF_BIT_FRESH_DATA]  = now[4] & ~prev_r[4];
      evtIf.evt[`MESF_BIT_ENGINE_DONE] = now[5] & ~prev_r[5];
      evtIf.evt[`MESF_BIT_SUPPLY_CHG]  = now[6] ^ prev_r[6];
    end
  end

  assign evtIf.armed = armed_r;
endmodule
`default_nettype wire

/* File: rtl/mesf_flags_top.sv */
// sticky event status flags with shadow copy, interrupt and Avalon-MM slave
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "mesf_defs.svh"
module mesf_flags_top
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire mesf_pkg::mesf_word_t avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output mesf_pkg::mesf_word_t   avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              energyPulseOne,
  input  wire logic              energyPulseTwo,
  input  wire logic              energyPulseThree,
  input  wire logic              energyPulseFour,
  input  wire logic              freshDataStrobe,
  input  wire logic              enginePassDone,
  input  wire logic              systemSupplyIndicator,
  output logic                   irq
);
  import mesf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic mesf_word_t mirrorWord(input mesf_flags_t f);
    mesf_word_t w;
    w = 32'h0000_0000;
    w[8:0] = f & `MESF_FLAG_MASK;
    w[`MESF_MIRROR_LSB+5:`MESF_MIRROR_LSB] = f[5:0];
    w[`MESF_MIRROR_RESET] = f[`MESF_BIT_RESET];
    mirrorWord = w;
  endfunction

  function automatic mesf_flags_t laneBits(input mesf_word_t d, input logic [3:0] be);
    mesf_flags_t m;
    m = {be[1], {8{be[0]}}};
    laneBits = d[8:0] & m & `MESF_FLAG_MASK;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  mesf_evt_if   evtIf ();
  mesf_bus_st_t busSt_r;
  mesf_word_t   readData_r;
  mesf_flags_t  flags_r;
  mesf_flags_t  flags_nxt;
  mesf_flags_t  snap_r;
  mesf_flags_t  shadow_r;
  mesf_flags_t  intStat_r;
  mesf_flags_t  intStat_nxt;
  mesf_flags_t  intEn_r;
  logic         irq_r;
  logic         req;
  logic         accept;
  logic         flagRdAcc;
  mesf_word_t   readMux;

  mesf_event_detect u_detect
  (
    .sys_clk               (sys_clk),
    .rst                   (rst),
    .energyPulseOne        (energyPulseOne),
    .energyPulseTwo        (energyPulseTwo),
    .energyPulseThree      (energyPulseThree),
    .energyPulseFour       (energyPulseFour),
    .freshDataStrobe       (freshDataStrobe),
    .enginePassDone        (enginePassDone),
    .systemSupplyIndicator (systemSupplyIndicator),
    .evtIf                 (evtIf.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, accept on second cycle
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & (busSt_r == BUS_IDLE);
  assign accept          = req & (busSt_r == BUS_ACK);
  assign flagRdAcc       = accept & avs_read & hit(avs_address, `MESF_IDX_FLAGS);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      busSt_r <= BUS_IDLE;
    else
    begin
      unique case (busSt_r)
        BUS_IDLE:
        begin
          if (req)
            busSt_r <= BUS_ACK;
        end
        BUS_ACK:
          busSt_r <= BUS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the wait cycle and held through the accept cycle
  always_comb
  begin
    readMux = 32'h0000_0000;
    if (hit(avs_address, `MESF_IDX_FLAGS))
      readMux = mirrorWord(flags_r);
    else if (hit(avs_address, `MESF_IDX_SHADOW))
      readMux = mirrorWord(shadow_r);
    else if (hit(avs_address, `MESF_IDX_INT_STAT))
      readMux = {23'h000000, intStat_r};
    else if (hit(avs_address, `MESF_IDX_INT_EN))
      readMux = {23'h000000, intEn_r};
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      readData_r <= 32'h0000_0000;
      snap_r     <= `MESF_SHADOW_RST;
    end
    else if (avs_read && busSt_r == BUS_IDLE)
    begin
      readData_r <= readMux;
      snap_r     <= flags_r;
    end
  end

  assign avs_readdata = readData_r;

  ////////////////////////////////////////////////////////////////////////////
  // event flags: only bits returned to the host clear; new events win
  always_comb
  begin
    flags_nxt = flags_r;
    if (flagRdAcc)
      flags_nxt = flags_nxt & ~snap_r;
    flags_nxt = flags_nxt | (evtIf.evt & `MESF_FLAG_MASK);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      flags_r <= `MESF_FLAGS_RST;
    else
      flags_r <= flags_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shadow copy of what the host just read
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      shadow_r <= `MESF_SHADOW_RST;
    else if (flagRdAcc)
      shadow_r <= snap_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, write-one-to-clear, enable and level output
  always_comb
  begin
    intStat_nxt = intStat_r;
    if (accept && avs_write && hit(avs_address, `MESF_IDX_INT_CLR))
      intStat_nxt = intStat_nxt & ~laneBits(avs_writedata, avs_byteenable);
    intStat_nxt = intStat_nxt | (evtIf.evt & `MESF_FLAG_MASK);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      intStat_r <= `MESF_INT_STAT_RST;
    else
      intStat_r <= intStat_nxt;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      intEn_r <= `MESF_INT_EN_RST;
    else if (accept && avs_write && hit(avs_address, `MESF_IDX_INT_EN))
    begin
      intEn_r[7:0] <= avs_byteenable[0] ? (avs_writedata[7:0] & 8'hbf) : intEn_r[7:0];
      intEn_r[8]   <= avs_byteenable[1] ? avs_writedata[8] : intEn_r[8];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_r <= 1'b0;
    else
      irq_r <= |(intStat_nxt & intEn_r);
  end

  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // helper terms for the checks
  logic        hostReadBits;
  logic        intClrAcc;
  logic        intEnAcc;
  logic        anyHit;
  mesf_flags_t clrBits;
  mesf_flags_t evtNow;
  assign hostReadBits = flagRdAcc;
  assign intClrAcc    = accept & avs_write & hit(avs_address, `MESF_IDX_INT_CLR);
  assign intEnAcc     = accept & avs_write & hit(avs_address, `MESF_IDX_INT_EN);
  assign anyHit       = hit(avs_address, `MESF_IDX_FLAGS)
                      | hit(avs_address, `MESF_IDX_SHADOW)
                      | hit(avs_address, `MESF_IDX_INT_STAT)
                      | hit(avs_address, `MESF_IDX_INT_EN);
  assign clrBits      = laneBits(avs_writedata, avs_byteenable);
  assign evtNow       = evtIf.evt;

  rst_flag_a: assert property ($past(rst) |-> flags_r == `MESF_FLAGS_RST)
    else $error("flags not 0x100 after reset");

  clear_read_a: assert property (flagRdAcc && evtIf.evt == 9'h000 |=>
    (flags_r & $past(snap_r)) == 9'h000)
    else $error("read flags not cleared");

  flags_hold_a: assert property (!hostReadBits |=>
    (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag lost without read");

  pulse_one_a: assert property ($rose(energyPulseOne) && evtIf.armed |=>
    flags_r[`MESF_BIT_PULSE_ONE])
    else $error("pulse one start not flagged");

  pulse_two_a: assert property ($rose(energyPulseTwo) && evtIf.armed |=>
    flags_r[`MESF_BIT_PULSE_TWO])
    else $error("pulse two start not flagged");

  pulse_three_a: assert property ($rose(energyPulseThree) && evtIf.armed |=>
    flags_r[`MESF_BIT_PULSE_THREE])
    else $error("pulse three start not flagged");

  pulse_four_a: assert property ($rose(energyPulseFour) && evtIf.armed |=>
    flags_r[`MESF_BIT_PULSE_FOUR])
    else $error("pulse four start not flagged");

  fresh_data_a: assert property ($rose(freshDataStrobe) && evtIf.armed |=>
    flags_r[`MESF_BIT_FRESH_DATA])
    else $error("fresh data not flagged");

  engine_done_a: assert property ($rose(enginePassDone) && evtIf.armed |=>
    flags_r[`MESF_BIT_ENGINE_DONE])
    else $error("engine pass not flagged");

  supply_chg_a: assert property ($changed(systemSupplyIndicator) && evtIf.armed
    |=> flags_r[`MESF_BIT_SUPPLY_CHG] && !flags_r[6])
    else $error("supply change not flagged");

  shadow_copy_a: assert property (flagRdAcc |=> shadow_r == $past(snap_r)
    && avs_readdata[8:0] == ($past(snap_r) & `MESF_FLAG_MASK))
    else $error("shadow not equal to read value");

  mirror_bits_a: assert property (flagRdAcc |->
    avs_readdata[21:16] == avs_readdata[5:0] && avs_readdata[24] == avs_readdata[8]
    && avs_readdata[15:9] == 7'h00 && avs_readdata[31:25] == 7'h00)
    else $error("mirror bits wrong");

  wait_one_a: assert property (req && busSt_r == BUS_IDLE |-> avs_waitrequest
    ##1 !avs_waitrequest)
    else $error("waitrequest not one cycle");

  prime_gap_a: assert property ($past(rst) |-> !evtIf.armed && evtNow == 9'h000)
    else $error("edge seen while detector priming");

  reset_vals_a: assert property ($past(rst) |-> shadow_r == `MESF_SHADOW_RST
    && intStat_r == `MESF_INT_STAT_RST && intEn_r == `MESF_INT_EN_RST && !irq)
    else $error("register not at reset value");

  reserved_six_a: assert property (!flags_r[6] && !shadow_r[6]
    && !intStat_r[6] && !intEn_r[6])
    else $error("reserved bit 6 set");

  no_spurious_a: assert property (evtNow == 9'h000 |=>
    (flags_r & ~$past(flags_r)) == 9'h000)
    else $error("flag set without event");

  set_wins_a: assert property (flagRdAcc |=>
    (flags_r & $past(evtNow)) == $past(evtNow))
    else $error("event lost in clearing read");

  keep_unread_a: assert property (flagRdAcc |=>
    ($past(flags_r) & ~$past(snap_r) & ~flags_r) == 9'h000)
    else $error("unread flag cleared");

  reset_bit_clr_a: assert property (flagRdAcc && snap_r[8] |=>
    !flags_r[`MESF_BIT_RESET])
    else $error("reset flag not cleared by read");

  read_snap_a: assert property (flagRdAcc |->
    avs_readdata[8:0] == (snap_r & `MESF_FLAG_MASK))
    else $error("read value differs from cleared bits");

  shadow_hold_a: assert property (!flagRdAcc |=> $stable(shadow_r))
    else $error("shadow changed without flag read");

  irq_on_a: assert property ((intStat_r & intEn_r) != 9'h000 && $stable(intEn_r) |-> irq)
    else $error("irq low with enabled status");

  irq_off_a: assert property ((intStat_r & intEn_r) == 9'h000 && $stable(intEn_r) |-> !irq)
    else $error("irq high with no enabled status");

  int_clear_a: assert property (intClrAcc && evtNow == 9'h000 |=>
    (intStat_r & $past(clrBits)) == 9'h000)
    else $error("int status not cleared");

  int_set_a: assert property (evtNow != 9'h000 |=>
    (intStat_r & $past(evtNow)) == $past(evtNow))
    else $error("int status missed event");

  int_en_write_a: assert property (intEnAcc && avs_byteenable[1:0] == 2'b11 |=>
    intEn_r == (9'($past(avs_writedata)) & `MESF_FLAG_MASK))
    else $error("enable write not taken");

  unmapped_zero_a: assert property (accept && avs_read && !anyHit |->
    avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  idle_no_wait_a: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");

  accept_once_a: assert property (accept |=> !accept)
    else $error("request accepted twice");

  reset_read_c: cover property ($past(rst) ##[1:20] flagRdAcc);
  clear_race_c: cover property (flagRdAcc && (evtIf.evt & snap_r) != 9'h000);
  irq_rise_c:   cover property ($rose(irq));
  shadow_c:     cover property (flagRdAcc ##[1:50] flagRdAcc && shadow_r != snap_r);
  int_clear_c:  cover property (intClrAcc && irq);
endmodule
`default_nettype wire

/* File: test/mesf_host_model.sv */
// host bus model: Avalon-MM master reading and writing the status registers
`timescale 1ns/1ps
`default_nettype none
module mesf_host_model
(
  input  wire logic                 sys_clk,
  output logic [11:0]               address,
  output logic                      read,
  output logic                      write,
  output mesf_pkg::mesf_word_t      writedata,
  output logic [3:0]                byteenable,
  input  wire mesf_pkg::mesf_word_t readdata,
  input  wire logic                 waitrequest
);
  import mesf_pkg::*;
  initial
  begin
    address = 12'h000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'hf;
  end
  // one word per request, held until waitrequest is seen low
  task automatic xfer(input logic wrEn, input logic [11:0] a, input mesf_word_t wd,
                      output mesf_word_t rdVal);
    @(posedge sys_clk);
    address <= a;
    writedata <= wd;
    read <= !wrEn;
    write <= wrEn;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0)
      @(posedge sys_clk);
    rdVal = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/meter_event_status_flags_tb.sv */
// self-checking bench for the event status flags block
`timescale 1ns/1ps
`default_nettype none
module meter_event_status_flags_tb;
  import mesf_pkg::*;
  logic       sys_clk;
  logic       rst;
  logic [11:0] addr;
  logic       rdEn;
  logic       wrEn;
  mesf_word_t wData;
  mesf_word_t rData;
  logic [3:0] be;
  logic       waitReq;
  logic [6:0] ev;
  logic       irq;
  int         errorCnt = 0;
  int         numChecks = 0;
  mesf_word_t got;
  mesf_flags_top DUT (.sys_clk(sys_clk), .rst(rst), .avs_address(addr), .avs_read(rdEn),
    .avs_write(wrEn), .avs_writedata(wData), .avs_byteenable(be), .avs_readdata(rData),
    .avs_waitrequest(waitReq), .energyPulseOne(ev[0]), .energyPulseTwo(ev[1]),
    .energyPulseThree(ev[2]), .energyPulseFour(ev[3]), .freshDataStrobe(ev[4]),
    .enginePassDone(ev[5]), .systemSupplyIndicator(ev[6]), .irq(irq));
  mesf_host_model host (.sys_clk(sys_clk), .address(addr), .read(rdEn), .write(wrEn),
    .writedata(wData), .byteenable(be), .readdata(rData), .waitrequest(waitReq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input mesf_word_t g, input mesf_word_t e, input string what);
    numChecks++;
    if (g !== e)
    begin
      errorCnt++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, g, e);
    end
  endtask
  task automatic rdChk(input logic [11:0] a, input mesf_word_t e, input string what);
    host.xfer(1'b0, a, 32'h0000_0000, got);
    chk(got, e, what);
  endtask
  task automatic wrReg(input logic [11:0] a, input mesf_word_t d);
    host.xfer(1'b1, a, d, got);
  endtask
  // event i of 0..6 fires once; the supply input changes level instead of pulsing
  task automatic fire(input int i);
    @(posedge sys_clk);
    ev[i] <= ~ev[i];
    @(posedge sys_clk);
    if (i < 6)
      ev[i] <= 1'b0;
    @(posedge sys_clk);
  endtask
  function automatic mesf_word_t expOf(input int b);
    expOf = 32'h0000_0001 << b;
    if (b < 6)
      expOf = expOf | (32'h0001_0000 << b);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic testReset;
    rdChk(12'hc40, 32'h0100_0100, "flags after reset");
    rdChk(12'hc44, 32'h0100_0100, "shadow after read");
    rdChk(12'hc40, 32'h0000_0000, "flags cleared by read");
    rdChk(12'hc00, 32'h0000_0000, "unmapped read");
    $display("test reset done");
  endtask
  task automatic testEach;
    int b;
    for (int i = 0; i < 8; i++)
    begin
      fire(i > 6 ? 6 : i);
      b = (i >= 6) ? 7 : i;
      rdChk(12'hc40, expOf(b), "single event flag");
      rdChk(12'hc40, 32'h0000_0000, "flag cleared");
    end
    $display("test each event done");
  endtask
  task automatic testSticky;
    @(posedge sys_clk);
    ev <= ~ev & 7'h3f | (ev & 7'h40) ^ 7'h40;
    @(posedge sys_clk);
    ev <= ev & 7'h40;
    repeat (5) @(posedge sys_clk);
    rdChk(12'hc40, 32'h003f_00bf, "all events held");
    rdChk(12'hc44, 32'h003f_00bf, "shadow of all");
    rdChk(12'hc40, 32'h0000_0000, "all cleared");
    rdChk(12'hc44, 32'h0000_0000, "shadow tracks read");
    $display("test sticky done");
  endtask
  task automatic testIrq;
    wrReg(12'hc4c, 32'h0000_01bf);
    wrReg(12'hc50, 32'h0000_0001);
    rdChk(12'hc50, 32'h0000_0001, "enable readback");
    fire(4);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0, "masked event no irq");
    fire(0);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h1, "enabled event irq");
    rdChk(12'hc48, 32'h0000_0011, "int status");
    rdChk(12'hc4c, 32'h0000_0000, "clear reads zero");
    wrReg(12'hc4c, 32'h0000_0011);
    @(negedge sys_clk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    rdChk(12'hc48, 32'h0000_0000, "int status cleared");
    rdChk(12'hc40, 32'h0011_0011, "flags unaffected by int clear");
    $display("test interrupt done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic closeOut;
    $display("checks %0d mismatches %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    errorCnt++;
    $display("[ERR] %0t watchdog expired", $time);
    closeOut;
  end
  initial
  begin
    rst = 1'b1;
    ev = 7'h00;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    testReset;
    testEach;
    testSticky;
    testIrq;
    closeOut;
  end
endmodule
`default_nettype wire
